//--- design/pgx_core.sv
// Paged call/return sequencer and program window address translation
`include "pgx_params.svh"

module pgx_core #(
   parameter bit HAS_EXPANSION = 1'b1,
   parameter bit REDUCED       = 1'b0
) (
   input  wire logic            ref_clk_i,
   input  wire logic            rst_i,
   input  wire logic            op_start_i,
   input  wire pgx_pkg::pgx_op_t op_kind_i,
   input  wire logic [7:0]      op_page_i,
   input  wire logic [15:0]     op_target_i,
   input  wire logic [15:0]     op_next_pc_i,
   input  wire logic [15:0]     op_sp_i,
   output logic                 op_busy_o,
   output logic                 op_done_o,
   output logic                 irq_hold_o,
   output logic                 mem_req_o,
   output logic                 mem_we_o,
   output logic [15:0]          mem_addr_o,
   output logic [7:0]           mem_wdata_o,
   input  wire logic            mem_ack_i,
   input  wire logic [7:0]      mem_rdata_i,
   output logic [15:0]          pc_load_o,
   output logic [15:0]          sp_o,
   output logic                 queue_refill_o,
   input  wire logic            page_wr_i,
   input  wire logic [7:0]      page_wdata_i,
   output logic [7:0]           program_page_select_o,
   input  wire logic            pwin_en_wr_i,
   input  wire logic            pwin_en_i,
   input  wire logic            xen_wr_i,
   input  wire logic [5:0]      xen_i,
   input  wire logic [15:0]     cpu_addr_i,
   output logic [21:16]         ext_addr_hi_o,
   output logic [19:14]         expansion_address_pins_o,
   output logic                 paged_access_o,
   output logic                 prog_cs_o
);

   localparam logic [7:0] PAGE_MASK = REDUCED ? 8'h3f : 8'hff;

   pgx_pkg::pgx_state_t state_reg, state_next;
   logic [7:0]  page_reg, page_next;
   logic [7:0]  tmp_page_reg, tmp_page_next;
   logic [15:0] ret_reg, ret_next;
   logic [15:0] tgt_reg, tgt_next;
   logic [15:0] sp_reg, sp_next;
   logic [15:0] ptr_reg, ptr_next;
   logic        pwin_en_reg;
   logic [5:0]  xen_reg;
   logic        refill_reg, refill_next;
   logic        done_reg, done_next;

   function automatic logic in_prog_win(input logic [15:0] a);
      in_prog_win = (a >= `PGX_WIN_LO) && (a <= `PGX_WIN_HI);
   endfunction

   function automatic logic [15:0] sp_add(input logic [15:0] s, input logic dec);
      sp_add = dec ? s - 16'h0001 : s + 16'h0001;
   endfunction

   // Reduced variant keeps only the low six page bits
   function automatic logic [7:0] mask_page(input logic [7:0] v);
      mask_page = v & PAGE_MASK;
   endfunction

   // States that hold a byte access until the memory answers
   function automatic logic is_mem_state(input pgx_pkg::pgx_state_t s);
      unique case (s)
         pgx_pkg::PGX_IND_PAGE,
         pgx_pkg::PGX_IND_ADRH,
         pgx_pkg::PGX_IND_ADRL,
         pgx_pkg::PGX_PUSH_RL,
         pgx_pkg::PGX_PUSH_RH,
         pgx_pkg::PGX_PUSH_PG,
         pgx_pkg::PGX_PULL_PG,
         pgx_pkg::PGX_PULL_RH,
         pgx_pkg::PGX_PULL_RL:  is_mem_state = 1'b1;
         default:               is_mem_state = 1'b0;
      endcase
   endfunction

   // States that write to the stack
   function automatic logic is_wr_state(input pgx_pkg::pgx_state_t s);
      unique case (s)
         pgx_pkg::PGX_PUSH_RL,
         pgx_pkg::PGX_PUSH_RH,
         pgx_pkg::PGX_PUSH_PG:  is_wr_state = 1'b1;
         default:               is_wr_state = 1'b0;
      endcase
   endfunction

   // Bits 21:14 of an access: page on an enabled window hit, ones above bit 15 otherwise
   function automatic logic [7:0] xlat_hi(input logic       act,
                                          input logic [7:0] pg,
                                          input logic [1:0] top);
      if (act) begin
         xlat_hi = pg;
      end else begin
         xlat_hi = {6'h3f, top};
      end
   endfunction

   // Window decode and translation
   wire        win_hit   = in_prog_win(cpu_addr_i);
   wire        win_act   = HAS_EXPANSION && pwin_en_reg && win_hit;
   wire [7:0]  page_eff  = mask_page(page_reg);
   wire [21:14] xlat     = xlat_hi(win_act, page_eff, cpu_addr_i[15:14]);
   wire [5:0]  hi_lines  = xlat[21:16] & xen_reg;
   wire        mem_phase = is_mem_state(state_reg);
   wire        wr_phase  = is_wr_state(state_reg);
   wire        step      = mem_phase && mem_ack_i;
   // Software page writes are refused while a call or return owns the page
   wire        page_wr_ok = page_wr_i && HAS_EXPANSION && !op_busy_o;

   assign op_busy_o      = state_reg != pgx_pkg::PGX_IDLE;
   assign irq_hold_o     = op_busy_o || op_start_i;
   assign op_done_o      = done_reg;
   assign queue_refill_o = refill_reg;
   assign pc_load_o      = tgt_reg;
   assign sp_o           = sp_reg;
   assign mem_req_o      = mem_phase;
   assign mem_we_o       = wr_phase;
   assign program_page_select_o = HAS_EXPANSION ? page_eff : 8'h00;
   assign ext_addr_hi_o  = hi_lines;
   assign expansion_address_pins_o = xlat[19:14];
   assign paged_access_o = expansion_address_pins_o[15:14] != cpu_addr_i[15:14];
   assign prog_cs_o      = win_hit;

   always_comb begin
      mem_addr_o = sp_reg;
      unique case (state_reg)
         pgx_pkg::PGX_IND_PAGE: mem_addr_o = ptr_reg;
         pgx_pkg::PGX_IND_ADRH: mem_addr_o = ptr_reg + 16'h0001;
         pgx_pkg::PGX_IND_ADRL: mem_addr_o = ptr_reg + 16'h0002;
         default:               mem_addr_o = sp_reg;
      endcase
   end

   always_comb begin
      mem_wdata_o = 8'h00;
      unique case (state_reg)
         pgx_pkg::PGX_PUSH_RL:  mem_wdata_o = ret_reg[7:0];
         pgx_pkg::PGX_PUSH_RH:  mem_wdata_o = ret_reg[15:8];
         pgx_pkg::PGX_PUSH_PG:  mem_wdata_o = tmp_page_reg;
         default:               mem_wdata_o = 8'h00;
      endcase
   end

   // Next-state and register updates of the call and return sequencer

   always_comb begin
      state_next    = state_reg;
      page_next     = page_reg;
      tmp_page_next = tmp_page_reg;
      ret_next      = ret_reg;
      tgt_next      = tgt_reg;
      sp_next       = sp_reg;
      ptr_next      = ptr_reg;
      refill_next   = 1'b0;
      done_next     = 1'b0;
      if (page_wr_ok) begin
         page_next = mask_page(page_wdata_i);
      end
      unique case (state_reg)
         pgx_pkg::PGX_IDLE: if (op_start_i) begin
            ret_next = op_next_pc_i;
            sp_next  = op_sp_i;
            unique case (op_kind_i)
               pgx_pkg::PGX_OP_CALL_IMM: begin
                  tmp_page_next = op_page_i;
                  tgt_next      = op_target_i;
                  state_next    = pgx_pkg::PGX_SWAP;
               end
               pgx_pkg::PGX_OP_CALL_IND: begin
                  ptr_next   = op_target_i;
                  state_next = pgx_pkg::PGX_IND_PAGE;
               end
               default: state_next = pgx_pkg::PGX_PULL_PG;
            endcase
         end
         pgx_pkg::PGX_IND_PAGE: if (step) begin
            tmp_page_next = mem_rdata_i;
            state_next    = pgx_pkg::PGX_IND_ADRH;
         end
         pgx_pkg::PGX_IND_ADRH: if (step) begin
            tgt_next[15:8] = mem_rdata_i;
            state_next     = pgx_pkg::PGX_IND_ADRL;
         end
         pgx_pkg::PGX_IND_ADRL: if (step) begin
            tgt_next[7:0] = mem_rdata_i;
            state_next    = pgx_pkg::PGX_SWAP;
         end
         pgx_pkg::PGX_SWAP: begin
            // Old page parks in the temporary while the new one goes live
            tmp_page_next = page_reg;
            if (HAS_EXPANSION) page_next = mask_page(tmp_page_reg);
            sp_next    = sp_add(sp_reg, 1'b1);
            state_next = pgx_pkg::PGX_PUSH_RL;
         end
         pgx_pkg::PGX_PUSH_RL: if (step) begin
            sp_next    = sp_add(sp_reg, 1'b1);
            state_next = pgx_pkg::PGX_PUSH_RH;
         end
         pgx_pkg::PGX_PUSH_RH: if (step) begin
            sp_next    = sp_add(sp_reg, 1'b1);
            state_next = pgx_pkg::PGX_PUSH_PG;
         end
         pgx_pkg::PGX_PUSH_PG: if (step) begin
            state_next = pgx_pkg::PGX_JUMP;
         end
         pgx_pkg::PGX_PULL_PG: if (step) begin
            tmp_page_next = mem_rdata_i;
            sp_next       = sp_add(sp_reg, 1'b0);
            state_next    = pgx_pkg::PGX_PULL_RH;
         end
         pgx_pkg::PGX_PULL_RH: if (step) begin
            tgt_next[15:8] = mem_rdata_i;
            sp_next        = sp_add(sp_reg, 1'b0);
            state_next     = pgx_pkg::PGX_PULL_RL;
         end
         pgx_pkg::PGX_PULL_RL: if (step) begin
            tgt_next[7:0] = mem_rdata_i;
            sp_next       = sp_add(sp_reg, 1'b0);
            state_next    = pgx_pkg::PGX_SET_PG;
         end
         pgx_pkg::PGX_SET_PG: begin
            if (HAS_EXPANSION) page_next = mask_page(tmp_page_reg);
            state_next = pgx_pkg::PGX_JUMP;
         end
         pgx_pkg::PGX_JUMP: begin
            refill_next = 1'b1;
            done_next   = 1'b1;
            state_next  = pgx_pkg::PGX_IDLE;
         end
         default: state_next = pgx_pkg::PGX_IDLE;
      endcase
   end

   // Sequencer state and the one-cycle completion pulses
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg  <= pgx_pkg::PGX_IDLE;
         refill_reg <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         refill_reg <= refill_next;
         done_reg   <= done_next;
      end
   end

   // Live page and the page parked during a call or return
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         page_reg     <= `PGX_PAGE_RST;
         tmp_page_reg <= `PGX_PAGE_RST;
      end else begin
         page_reg     <= page_next;
         tmp_page_reg <= tmp_page_next;
      end
   end

   // Return address and jump target
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ret_reg <= 16'h0000;
         tgt_reg <= 16'h0000;
      end else begin
         ret_reg <= ret_next;
         tgt_reg <= tgt_next;
      end
   end

   // Working stack pointer and indirect call pointer
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sp_reg  <= 16'h0000;
         ptr_reg <= 16'h0000;
      end else begin
         sp_reg  <= sp_next;
         ptr_reg <= ptr_next;
      end
   end

   // Program window enable, cleared by reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pwin_en_reg <= `PGX_PWIN_EN_RST;
      end else if (pwin_en_wr_i) begin
         pwin_en_reg <= pwin_en_i;
      end
   end

   // Per-line enables, cleared by reset; none exist without expansion
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         xen_reg <= `PGX_XEN_RST;
      end else if (xen_wr_i) begin
         xen_reg <= HAS_EXPANSION ? xen_i : 6'h00;
      end
   end

endmodule

//--- design/pgx_params.svh
// Constants for the paged call and address expansion block
// Function
// - Paged call saves current page into temporary, then loads new page.
// - Paged call then pushes the 16-bit return address onto the stack.
// - Paged call then pushes the saved 8-bit former page onto the stack.
// - Paged call finally jumps to subroutine address, refilling the queue.
// - Paged call is atomic; interrupts wait; works from any address to any.
// - Except indexed indirect, new page comes from an immediate operand.
// - Indexed indirect fetches both page and subroutine address through pointer.
// - Paged return first pulls the 8-bit page from the stack.
// - Paged return then pulls 16-bit return address into program counter.
// - Paged return then writes page register, refills queue, resumes.
// - Paged return is one non-interruptible instruction.
// - Without expansion, sequences still run; page reads are undefined.
// - Without expansion, page writes do nothing and no translation occurs.
// - Page value picks one of 256 pages in 16-Kbyte program window.
// - Up to six extra address lines, each gated by its own enable.
// - Enabled window hit drives page contents onto high address lines.
// - Program window hit drives page onto bits 19:14; 14 low lines inside.
// - Outside enabled windows, enabled lines 19 to 16 are driven high.
// - Separate pins; paged access when cpu bits 15:14 differ from expansion.
// - Expansion is disabled after reset until software sets enables.
// - Page register at most 8 bits; reduced variant uses 6 bits.
// - Chip select detects its address range and asserts an enable.
// - Program chip select matches every access in the overlay range.
`ifndef PGX_PARAMS_SVH
`define PGX_PARAMS_SVH
`define PGX_PAGE_W       8
`define PGX_EXPANSION_ADDRESS_PINS_HI     21
`define PGX_EXPANSION_ADDRESS_PINS_LO     14
`define PGX_WIN_LO       16'h8000
`define PGX_WIN_HI       16'hbfff
`define PGX_PAGE_RST     8'h00
`define PGX_XEN_RST      6'h00
`define PGX_PWIN_EN_RST  1'b0
`endif

//--- design/pgx_pkg.sv
// Types of the paged call and address expansion block
package pgx_pkg;
   typedef enum logic [1:0] {
      PGX_OP_CALL_IMM,
      PGX_OP_CALL_IND,
      PGX_OP_RTC
   } pgx_op_t;
   typedef enum logic [3:0] {
      PGX_IDLE,
      PGX_IND_PAGE,
      PGX_IND_ADRH,
      PGX_IND_ADRL,
      PGX_SWAP,
      PGX_PUSH_RL,
      PGX_PUSH_RH,
      PGX_PUSH_PG,
      PGX_PULL_PG,
      PGX_PULL_RH,
      PGX_PULL_RL,
      PGX_SET_PG,
      PGX_JUMP
   } pgx_state_t;
endpackage

//--- verification/pgx_checker.sv
// Checker for the paged call sequencer and program window translation
module pgx_checker (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        op_start_i,
   input wire logic        op_busy_o,
   input wire logic        op_done_o,
   input wire logic        irq_hold_o,
   input wire logic        mem_req_o,
   input wire logic        mem_we_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic        mem_ack_i,
   input wire logic        queue_refill_o,
   input wire logic        page_wr_i,
   input wire logic [7:0]  program_page_select_o,
   input wire logic [15:0] cpu_addr_i,
   input wire logic [21:16] ext_addr_hi_o,
   input wire logic [19:14] expansion_address_pins_o,
   input wire logic        paged_access_o,
   input wire logic        prog_cs_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   AST_CS: assert property (prog_cs_o == (cpu_addr_i inside {[16'h8000:16'hbfff]}))
      else $error("program chip select mismatch");
   AST_OUTSIDE: assert property (!prog_cs_o |-> expansion_address_pins_o[19:16] == 4'hf)
      else $error("high lines not driven high outside window");
   AST_PAGED: assert property (paged_access_o ==
      (expansion_address_pins_o[15:14] != cpu_addr_i[15:14]))
      else $error("paged access flag mismatch");
   AST_IRQ: assert property (op_busy_o || op_start_i |-> irq_hold_o)
      else $error("interrupt not held during sequence");
   AST_LEN: assert property (op_start_i && !op_busy_o |=>
      (op_busy_o && !op_done_o) [*5] ##[1:60] op_done_o)
      else $error("sequence length wrong");
   AST_DONE: assert property (op_done_o |-> queue_refill_o && !op_busy_o ##1 !op_done_o)
      else $error("done and refill not paired");
   AST_HOLD: assert property (mem_req_o && !mem_ack_i |=>
      mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
      else $error("memory request dropped before answer");
   AST_PAGE: assert property (!op_busy_o && !op_start_i && !page_wr_i |=>
      $stable(program_page_select_o))
      else $error("page changed while idle");
   AST_RST: assert property ($fell(rst_i) |-> !op_busy_o &&
      program_page_select_o == 8'h00 && ext_addr_hi_o == 6'h00)
      else $error("reset state wrong");
   CV_START: cover property (op_start_i && !op_busy_o);
   CV_DONE: cover property (op_done_o);
   CV_PAGED: cover property (paged_access_o && prog_cs_o);
endmodule

bind pgx_core pgx_checker u_chk (.ref_clk_i, .rst_i, .op_start_i, .op_busy_o, .op_done_o,
   .irq_hold_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i, .queue_refill_o, .page_wr_i,
   .program_page_select_o, .cpu_addr_i, .ext_addr_hi_o, .expansion_address_pins_o,
   .paged_access_o, .prog_cs_o);

//--- verification/pgx_mem_model.sv
// Byte memory holding the stack and call pointers, answering lat_i + 1 cycles after a request
module pgx_mem_model (
   input  wire logic        ref_clk_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic [1:0]  lat_i,
   output logic             ack_o,
   output logic [7:0]       rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [bit [15:0]];
   logic [1:0] wait_reg = 2'h0;
   initial ack_o = 1'b0;
   initial rdata_o = 8'h00;
   always @(posedge ref_clk_i) begin
      if (req_i && !ack_o && wait_reg == lat_i) begin
         ack_o <= 1'b1;
         wait_reg <= 2'h0;
         if (we_i) mem[addr_i] = wdata_i;
         rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 8'h00;
      end else begin
         // Outside an answer the data lines keep changing
         ack_o <= 1'b0;
         wait_reg <= (req_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
         rdata_o <= ~rdata_o;
      end
   end
endmodule

//--- verification/paged_call_and_address_expansion_tb_top.sv
// Self-checking bench for the paged call sequencer and window translation
module paged_call_and_address_expansion_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, op_start_i = 1'b0, page_wr_i = 1'b0;
   logic pwin_en_wr_i = 1'b0, pwin_en_i = 1'b0, xen_wr_i = 1'b0;
   pgx_pkg::pgx_op_t op_kind_i = pgx_pkg::PGX_OP_CALL_IMM;
   logic [7:0] op_page_i = 8'h00, page_wdata_i = 8'h00, mem_rdata_i, mem_wdata_o;
   logic [7:0] program_page_select_o;
   logic [15:0] op_target_i = 16'h0000, op_next_pc_i = 16'h0000, op_sp_i = 16'h0000;
   logic [15:0] cpu_addr_i = 16'h9000, mem_addr_o, pc_load_o, sp_o;
   logic [5:0] xen_i = 6'h00;
   logic [1:0] lat = 2'h0;
   logic [21:16] ext_addr_hi_o;
   logic [19:14] expansion_address_pins_o;
   logic op_busy_o, op_done_o, irq_hold_o, mem_req_o, mem_we_o, mem_ack_i;
   logic queue_refill_o, paged_access_o, prog_cs_o;
   int error_cnt = 0, samples_checked = 0;
   always #10 ref_clk_i = ~ref_clk_i;
   pgx_core dut (.ref_clk_i, .rst_i, .op_start_i, .op_kind_i, .op_page_i, .op_target_i,
      .op_next_pc_i, .op_sp_i, .op_busy_o, .op_done_o, .irq_hold_o, .mem_req_o, .mem_we_o,
      .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .pc_load_o, .sp_o, .queue_refill_o,
      .page_wr_i, .page_wdata_i, .program_page_select_o, .pwin_en_wr_i, .pwin_en_i, .xen_wr_i,
      .xen_i, .cpu_addr_i, .ext_addr_hi_o, .expansion_address_pins_o, .paged_access_o,
      .prog_cs_o);
   pgx_mem_model u_mem (.ref_clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Start held two cycles: the second start and changed kind arrive while busy
   task automatic run_op(input pgx_pkg::pgx_op_t k, input logic [7:0] pg,
                         input logic [15:0] tgt, nxt, sp, input logic [1:0] l);
      int i;
      @(posedge ref_clk_i);
      op_kind_i <= k;
      op_page_i <= pg;
      op_target_i <= tgt;
      op_next_pc_i <= nxt;
      op_sp_i <= sp;
      lat <= l;
      op_start_i <= 1'b1;
      @(posedge ref_clk_i);
      op_kind_i <= (k == pgx_pkg::PGX_OP_RTC) ? pgx_pkg::PGX_OP_CALL_IMM : pgx_pkg::PGX_OP_RTC;
      @(posedge ref_clk_i);
      op_start_i <= 1'b0;
      for (i = 0; i < 100 && op_done_o !== 1'b1; i++) @(negedge ref_clk_i);
      if (i == 100) begin
         error_cnt++;
         $display("ERROR %0t no done", $time);
         close_out();
      end
      chk(queue_refill_o, 1'b1);
   endtask
   task automatic set_x(input logic [15:0] a, input logic [5:0] x);
      @(posedge ref_clk_i);
      cpu_addr_i <= a;
      xen_i <= x;
      xen_wr_i <= 1'b1;
      pwin_en_wr_i <= 1'b1;
      pwin_en_i <= 1'b1;
      @(posedge ref_clk_i);
      xen_wr_i <= 1'b0;
      pwin_en_wr_i <= 1'b0;
      @(negedge ref_clk_i);
   endtask
   task automatic test_reset();
      @(negedge ref_clk_i);
      chk(program_page_select_o, 8'h00);
      chk(ext_addr_hi_o, 6'h00);
      chk(expansion_address_pins_o, 6'h3e);
      @(posedge ref_clk_i);
      page_wr_i <= 1'b1;
      page_wdata_i <= 8'h05;
      @(posedge ref_clk_i);
      page_wr_i <= 1'b0;
      @(negedge ref_clk_i);
      chk(program_page_select_o, 8'h05);
      $display("reset and page write finished");
   endtask
   task automatic test_call_imm();
      run_op(pgx_pkg::PGX_OP_CALL_IMM, 8'h2a, 16'h9100, 16'hc010, 16'h1000, 2'h0);
      chk(program_page_select_o, 8'h2a);
      chk(pc_load_o, 16'h9100);
      chk(u_mem.mem[16'h0fff], 8'h10);
      chk(u_mem.mem[16'h0ffe], 8'hc0);
      chk(u_mem.mem[16'h0ffd], 8'h05);
      chk(sp_o, 16'h0ffd);
      $display("immediate call finished");
   endtask
   task automatic test_rtc();
      run_op(pgx_pkg::PGX_OP_RTC, 8'h00, 16'h0000, 16'h0000, 16'h0ffd, 2'h2);
      chk(program_page_select_o, 8'h05);
      chk(pc_load_o, 16'hc010);
      chk(sp_o, 16'h1000);
      $display("return finished");
   endtask
   task automatic test_call_ind();
      u_mem.mem[16'h2000] = 8'h3c;
      u_mem.mem[16'h2001] = 8'ha1;
      u_mem.mem[16'h2002] = 8'h23;
      run_op(pgx_pkg::PGX_OP_CALL_IND, 8'h77, 16'h2000, 16'h4321, 16'h1800, 2'h1);
      chk(program_page_select_o, 8'h3c);
      chk(pc_load_o, 16'ha123);
      chk(u_mem.mem[16'h17ff], 8'h21);
      chk(u_mem.mem[16'h17fd], 8'h05);
      $display("indirect call finished");
   endtask
   task automatic test_xlat();
      set_x(16'h9000, 6'h3f);
      chk(expansion_address_pins_o, 6'h3c);
      chk(ext_addr_hi_o, 6'h0f);
      chk(paged_access_o, 1'b1);
      set_x(16'hc000, 6'h3f);
      chk(ext_addr_hi_o, 6'h3f);
      chk(prog_cs_o, 1'b0);
      set_x(16'hc000, 6'h0f);
      chk(ext_addr_hi_o, 6'h0f);
      $display("translation finished");
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      test_reset();
      test_call_imm();
      test_rtc();
      test_call_ind();
      test_xlat();
      close_out();
   end
endmodule
